// [rtl/tbcd_pkg.sv]
// Constants, register layout and state types of the bus connect/disconnect detector.
package tbcd_pkg;

    // Register port geometry.
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    // Register offsets.
    localparam logic [2:0] CTRL_STATUS_OFS = 3'h0;
    localparam logic [2:0] EVT_STATUS_OFS  = 3'h1;
    localparam logic [2:0] EVT_MASK_OFS    = 3'h2;
    localparam logic [2:0] LINE_STATE_OFS  = 3'h3;

    // Field positions of bus_change_ctrl_status.
    localparam int unsigned FLAG_BIT   = 7;
    localparam int unsigned IRQ_EN_BIT = 6;
    localparam int unsigned TSEL_HI    = 2;
    localparam int unsigned TSEL_LO    = 1;
    localparam int unsigned POL_BIT    = 0;

    // Event bits shared by the status and mask registers.
    localparam int unsigned EVT_W          = 3;
    localparam int unsigned EVT_CONNECT    = 0;
    localparam int unsigned EVT_DISCONNECT = 1;
    localparam int unsigned EVT_FLAG_SET   = 2;

    // Field positions of the line state register.
    localparam int unsigned LS_SDA_BIT    = 0;
    localparam int unsigned LS_SCL_BIT    = 1;
    localparam int unsigned LS_TIMING_BIT = 2;

    // Values after reset.
    localparam logic [1:0]       TSEL_RESET = 2'h0;
    localparam logic             POL_RESET  = 1'b0;
    localparam logic             IEN_RESET  = 1'b0;
    localparam logic [EVT_W-1:0] EVT_RESET  = 3'h0;
    localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
    localparam logic [1:0]       SYNC_RESET = 2'h0;

    // Time-out periods and the cycle counts derived from the clock rate.
    localparam longint unsigned CLK_PERIOD_NS = 8;
    localparam longint unsigned NS_PER_MS     = 1_000_000;
    localparam longint unsigned TOUT0_MS      = 250;
    localparam longint unsigned TOUT1_MS      = 500;
    localparam longint unsigned TOUT2_MS      = 1000;
    localparam longint unsigned TOUT3_MS      = 2000;
    localparam int unsigned     TIMER_W       = 28;
    localparam logic [TIMER_W-1:0] TOUT0_CYCLES =
        TIMER_W'((TOUT0_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] TOUT1_CYCLES =
        TIMER_W'((TOUT1_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] TOUT2_CYCLES =
        TIMER_W'((TOUT2_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] TOUT3_CYCLES =
        TIMER_W'((TOUT3_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Cycles after reset release until the synchronisers hold real line levels.
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;

    // Start-up sequencer.
    typedef enum logic [1:0] {
        TBCD_SETTLE,
        TBCD_SAMPLE,
        TBCD_RUN
    } tbcd_init_t;

endpackage

// [rtl/tbcd_low_timer.sv]
// Time-out counter that measures how long both bus lines stay low.
`timescale 1ns/1ns
`default_nettype none

module tbcd_low_timer (
    // Clock, reset and enable.
    input  wire logic                        clk_in,
    input  wire logic                        rstn_in,
    input  wire logic                        clk_en_in,
    // Measurement.
    input  wire logic                        run_in,
    input  wire logic [tbcd_pkg::TIMER_W-1:0] limit_in,
    output logic                             expired_out,
    output logic                             timing_out
);

    logic [tbcd_pkg::TIMER_W-1:0] cnt_q;
    logic                         fired_q;
    logic                         expired_q;

    // A limit lowered below the current count still expires at once.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q     <= '0;
            fired_q   <= 1'b0;
            expired_q <= 1'b0;
        end else if (clk_en_in) begin
            expired_q <= 1'b0;
            if (!run_in) begin
                cnt_q   <= '0; // [R11]
                fired_q <= 1'b0;
            end else if (!fired_q) begin
                if (cnt_q >= limit_in - 1'b1) begin
                    expired_q <= 1'b1; // [R2]
                    fired_q   <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    assign expired_out = expired_q;
    assign timing_out  = run_in & ~fired_q;

endmodule

`default_nettype wire

// [rtl/tbcd_detector.sv]
// Two-wire bus connect/disconnect detector with its control register and event interrupt.
//
// Operation
// R1 - Both bus lines becoming high together is a connect, which sets the change flag when polarity is clear.
// R2 - With polarity set, both lines low for the whole selected time-out is a disconnect that sets the flag.
// R3 - Time-out select bits 2:1 choose 250 ms, 500 ms, 1000 ms or 2000 ms for codes 00 to 11.
// R4 - Polarity bit 0 picks connect when clear and disconnect when set as the flag-setting event.
// R5 - Executing the matching interrupt vector clears the change flag in hardware.
// R6 - Writing one to the change flag clears it and writing zero leaves it alone.
// R7 - The interrupt request stands only while flag bit 7, enable bit 6 and the global enable are set.
// R8 - After reset the flag is set if both lines were high, otherwise it stays clear.
// R9 - Bits 5 to 3 are reserved and always read as zero.
// R10 - Software should set polarity after a connect to arm disconnect detection and stop repeats.
// R11 - The disconnect counter restarts whenever a line is seen high, and lines pass synchronisers.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none

module tbcd_detector #(
    parameter logic [tbcd_pkg::TIMER_W-1:0] TOUT0_CYCLES = tbcd_pkg::TOUT0_CYCLES,
    parameter logic [tbcd_pkg::TIMER_W-1:0] TOUT1_CYCLES = tbcd_pkg::TOUT1_CYCLES,
    parameter logic [tbcd_pkg::TIMER_W-1:0] TOUT2_CYCLES = tbcd_pkg::TOUT2_CYCLES,
    parameter logic [tbcd_pkg::TIMER_W-1:0] TOUT3_CYCLES = tbcd_pkg::TOUT3_CYCLES
) (
    // Clock, reset and enable.
    input  wire logic                        clk_in,
    input  wire logic                        rstn_in,
    input  wire logic                        clk_en_in,

    // Bus lines as seen at the pins.
    input  wire logic                        sda_in,
    input  wire logic                        scl_in,

    // Processor interrupt side.
    input  wire logic                        global_irq_en_in,
    input  wire logic                        vector_ack_in,
    output logic                             bus_change_irq_out,
    output logic                             event_irq_out,

    // Register port.
    input  wire logic [tbcd_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [tbcd_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    output logic      [tbcd_pkg::DATA_W-1:0] rdata_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    // Line sampling.
    logic [1:0]                      sync1_q;
    logic [1:0]                      sync2_q;
    logic [1:0]                      lines_raw;
    logic                            sda_s;
    logic                            scl_s;
    logic                            both_high;
    logic                            both_low;
    logic                            both_high_prev_q;

    // Start-up sequencing.
    tbcd_pkg::tbcd_init_t            init_q;
    logic [1:0]                      settle_cnt_q;
    logic                            running;
    logic                            startup_set;

    // Control fields.
    logic                            flag_q;
    logic                            irq_en_q;
    logic [1:0]                      tsel_q;
    logic                            pol_q;

    // Event status and mask.
    logic [tbcd_pkg::EVT_W-1:0]      evt_q;
    logic [tbcd_pkg::EVT_W-1:0]      mask_q;
    logic [tbcd_pkg::EVT_W-1:0]      evt_hit;

    // Detection and time-out.
    logic                            connect_evt;
    logic                            disconnect_evt;
    logic                            flag_set;
    logic                            flag_clr;
    logic                            timer_run;
    logic                            timer_expired;
    logic                            timer_busy;
    logic [tbcd_pkg::TIMER_W-1:0]    timer_limit;

    // Register port decode.
    logic                            wr_ctrl;
    logic                            wr_evt;
    logic                            wr_mask;
    logic [tbcd_pkg::DATA_W-1:0]     ctrl_view;
    logic [tbcd_pkg::DATA_W-1:0]     rd_value;
    logic [tbcd_pkg::DATA_W-1:0]     rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Line synchronisers.

    assign lines_raw = {scl_in, sda_in};

    // Both lines pass a two-stage synchroniser, so only the second stage is ever looked at.
    generate
        for (genvar i = 0; i < 2; i++) begin : g_sync
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    sync1_q[i] <= tbcd_pkg::SYNC_RESET[i];
                    sync2_q[i] <= tbcd_pkg::SYNC_RESET[i];
                end else if (clk_en_in) begin
                    sync1_q[i] <= lines_raw[i]; // [R11]
                    sync2_q[i] <= sync1_q[i];
                end
            end
        end
    endgenerate

    // The chain resets low, not to the idle-high level of the lines.
    assign sda_s     = sync2_q[0];
    assign scl_s     = sync2_q[1];
    assign both_high = sda_s & scl_s;
    assign both_low  = ~sda_s & ~scl_s;

    ////////////////////////////////////////////////////////////////////////////
    // Start-up sequencer.

    // The strap-like start-up check waits until the synchronisers carry real levels,
    // because the reset state of the chain says nothing about the lines.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            init_q       <= tbcd_pkg::TBCD_SETTLE;
            settle_cnt_q <= 2'h0;
        end else if (clk_en_in) begin
            case (init_q)
                tbcd_pkg::TBCD_SETTLE: begin
                    settle_cnt_q <= settle_cnt_q + 2'h1;
                    if (settle_cnt_q == tbcd_pkg::SETTLE_CYCLES - 2'h1) begin
                        init_q <= tbcd_pkg::TBCD_SAMPLE;
                    end
                end
                tbcd_pkg::TBCD_SAMPLE: begin
                    init_q <= tbcd_pkg::TBCD_RUN;
                end
                default: begin
                    init_q <= tbcd_pkg::TBCD_RUN;
                end
            endcase
        end
    end

    // A connect during the settle cycles is left to the start-up check,
    // which reads the same synchronised levels as the detector does.
    assign running     = (init_q == tbcd_pkg::TBCD_RUN);
    assign startup_set = (init_q == tbcd_pkg::TBCD_SAMPLE) & both_high; // [R8]

    ////////////////////////////////////////////////////////////////////////////
    // Connect and disconnect detection.

    // The previous level is primed during start-up, so lines already high at reset
    // are reported once by the start-up check and not a second time as an edge.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            both_high_prev_q <= 1'b0;
        end else if (clk_en_in) begin
            both_high_prev_q <= both_high;
        end
    end

    // A line bouncing while the other stays low starts no connect.
    assign connect_evt = running & both_high & ~both_high_prev_q; // [R1]

    // The timer runs only while both lines are low and restarts on any high level.
    assign timer_run = running & both_low; // [R11]

    // A select change in mid-count keeps the count and takes the new limit,
    // so a shorter period chosen late may expire on the next edge.
    always_comb begin
        case (tsel_q)
            2'h0:    timer_limit = TOUT0_CYCLES; // [R3]
            2'h1:    timer_limit = TOUT1_CYCLES; // [R3]
            2'h2:    timer_limit = TOUT2_CYCLES; // [R3]
            default: timer_limit = TOUT3_CYCLES; // [R3]
        endcase
    end

    // Kept apart so that a prescaled counter can replace it if fewer bits are wanted.
    tbcd_low_timer u_low_timer (
        .clk_in      (clk_in),
        .rstn_in     (rstn_in),
        .clk_en_in   (clk_en_in),
        .run_in      (timer_run),
        .limit_in    (timer_limit),
        .expired_out (timer_expired),
        .timing_out  (timer_busy)
    );

    // A disconnect is reported once per low period, when the full time-out has passed.
    // A line rising in the very cycle of expiry cancels the report.
    assign disconnect_evt = timer_expired & both_low; // [R2]

    ////////////////////////////////////////////////////////////////////////////
    // Register write decode.

    // The line state register and unmapped offsets decode to no write.
    always_comb begin
        wr_ctrl = 1'b0;
        wr_evt  = 1'b0;
        wr_mask = 1'b0;
        if (wr_in && addr_in == tbcd_pkg::CTRL_STATUS_OFS) begin
            wr_ctrl = 1'b1;
        end else if (wr_in && addr_in == tbcd_pkg::EVT_STATUS_OFS) begin
            wr_evt = 1'b1;
        end else if (wr_in && addr_in == tbcd_pkg::EVT_MASK_OFS) begin
            wr_mask = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Change flag.

    // Polarity chooses which of the two events may set the flag.
    assign flag_set = startup_set
                    | (~pol_q & connect_evt)     // [R4]
                    | (pol_q & disconnect_evt);  // [R4]

    // The vector acknowledge and a written one share a single clear path.
    assign flag_clr = vector_ack_in                                   // [R5]
                    | (wr_ctrl & wdata_in[tbcd_pkg::FLAG_BIT]);       // [R6]

    // A set arriving together with a clear wins, so no bus change is lost.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flag_q <= 1'b0;
        end else if (clk_en_in) begin
            if (flag_set) begin
                flag_q <= 1'b1;
            end else if (flag_clr) begin
                flag_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control fields.

    // Software is expected to set polarity after a connect; hardware never flips it,
    // so a bus left idle high with polarity clear raises no further flags. [R10]
    // The flag bit of a written word is a clear request and is not stored here.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_en_q <= tbcd_pkg::IEN_RESET;
            tsel_q   <= tbcd_pkg::TSEL_RESET;
            pol_q    <= tbcd_pkg::POL_RESET;
        end else if (clk_en_in && wr_ctrl) begin
            irq_en_q <= wdata_in[tbcd_pkg::IRQ_EN_BIT];
            tsel_q   <= wdata_in[tbcd_pkg::TSEL_HI:tbcd_pkg::TSEL_LO]; // [R3]
            pol_q    <= wdata_in[tbcd_pkg::POL_BIT];                   // [R4]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event status and mask.

    // The flag-set event includes the start-up set.
    assign evt_hit[tbcd_pkg::EVT_CONNECT]    = connect_evt;
    assign evt_hit[tbcd_pkg::EVT_DISCONNECT] = disconnect_evt;
    assign evt_hit[tbcd_pkg::EVT_FLAG_SET]   = flag_set;

    // Sticky bits clear on a written one, and a new event in that cycle keeps its bit set.
    generate
        for (genvar e = 0; e < tbcd_pkg::EVT_W; e++) begin : g_evt
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    evt_q[e] <= tbcd_pkg::EVT_RESET[e];
                end else if (clk_en_in) begin
                    if (evt_hit[e]) begin
                        evt_q[e] <= 1'b1;
                    end else if (wr_evt && wdata_in[e]) begin
                        evt_q[e] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // The mask only gates the event interrupt; status bits record every event,
    // so software may poll with that interrupt switched off.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask_q <= tbcd_pkg::MASK_RESET;
        end else if (clk_en_in && wr_mask) begin
            mask_q <= wdata_in[tbcd_pkg::EVT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt outputs.

    // The change interrupt stays combinational so that a dropped global enable
    // takes effect in the same cycle; the event interrupt uses registers only.
    assign bus_change_irq_out = flag_q & irq_en_q & global_irq_en_in; // [R7]
    assign event_irq_out      = |(evt_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // Register read path.

    // Reads have no side effects, so polling never loses an event.
    always_comb begin
        ctrl_view = '0; // [R9]
        ctrl_view[tbcd_pkg::FLAG_BIT]   = flag_q;
        ctrl_view[tbcd_pkg::IRQ_EN_BIT] = irq_en_q;
        ctrl_view[tbcd_pkg::TSEL_HI:tbcd_pkg::TSEL_LO] = tsel_q;
        ctrl_view[tbcd_pkg::POL_BIT]    = pol_q;
    end

    // Unmapped offsets read as zero.
    always_comb begin
        rd_value = '0;
        if (addr_in == tbcd_pkg::CTRL_STATUS_OFS) begin
            rd_value = ctrl_view;
        end else if (addr_in == tbcd_pkg::EVT_STATUS_OFS) begin
            rd_value[tbcd_pkg::EVT_W-1:0] = evt_q;
        end else if (addr_in == tbcd_pkg::EVT_MASK_OFS) begin
            rd_value[tbcd_pkg::EVT_W-1:0] = mask_q;
        end else if (addr_in == tbcd_pkg::LINE_STATE_OFS) begin
            rd_value[tbcd_pkg::LS_SDA_BIT]    = sda_s;
            rd_value[tbcd_pkg::LS_SCL_BIT]    = scl_s;
            rd_value[tbcd_pkg::LS_TIMING_BIT] = timer_busy;
        end
    end

    // Read data stand only in the cycle after the strobe and are zero otherwise.
    // Zero outside the answer cycle lets several read ports be ORed together.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= '0;
        end else if (clk_en_in) begin
            rdata_q <= rd_in ? rd_value : '0;
        end
    end

    assign rdata_out = rdata_q;

endmodule

`default_nettype wire

// [verification/tbcd_properties.sv]
// Port-level checks of the bus connect/disconnect detector.
`timescale 1ns/1ns
`default_nettype none
module tbcd_properties #(
    parameter logic [tbcd_pkg::TIMER_W-1:0] TOUT0_CYCLES = 28'h14
) (
    // Clock, reset and enable.
    input wire logic       clk_in,
    input wire logic       rstn_in,
    input wire logic       clk_en_in,
    // Bus lines and interrupt side.
    input wire logic       sda_in,
    input wire logic       scl_in,
    input wire logic       global_irq_en_in,
    input wire logic       vector_ack_in,
    input wire logic       bus_change_irq_out,
    input wire logic       event_irq_out,
    // Register port.
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    ////////////////////////////////////////////////////////////////////////
    // Pin-level low time; any high line restarts it, like the real timer.
    logic [7:0] low_cnt_q;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) low_cnt_q <= 8'h00;
        else if (sda_in || scl_in) low_cnt_q <= 8'h00;
        else if (low_cnt_q != 8'hFF) low_cnt_q <= low_cnt_q + 8'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    a_irq_global_gate: assert property (!global_irq_en_in |-> !bus_change_irq_out)
        else $error("irq high without global enable");
    a_rdata_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside read cycle");
    a_reserved_read_zero: assert property ($past(rd_in) && $past(addr_in) == 3'h0
        |-> rdata_out[5:3] == 3'h0) else $error("reserved bits not zero");
    a_irq_rise_cause: assert property ($rose(bus_change_irq_out) |->
        $rose(global_irq_en_in) || $past(wr_in) || ($past(sda_in, 3) == $past(scl_in, 3)))
        else $error("irq rose without a cause");
    a_vector_clears_irq: assert property (vector_ack_in |=> !bus_change_irq_out)
        else $error("vector did not clear flag");
    a_flag_one_clears: assert property (wr_in && addr_in == 3'h0 && wdata_in[7]
        |=> !bus_change_irq_out) else $error("write one kept flag");
    a_zero_keeps_flag: assert property (wr_in && addr_in == 3'h0
        && wdata_in[7:6] == 2'b01 && bus_change_irq_out && global_irq_en_in
        && !vector_ack_in ##1 global_irq_en_in |-> bus_change_irq_out)
        else $error("write zero cleared flag");
    a_disc_low_time: assert property ($rose(bus_change_irq_out) && !$past(wr_in)
        && !$rose(global_irq_en_in) && !$past(sda_in, 3)
        |-> {20'h0, low_cnt_q} >= TOUT0_CYCLES) else $error("disconnect too early");
endmodule
bind tbcd_detector tbcd_properties #(.TOUT0_CYCLES(TOUT0_CYCLES)) u_props (
    .clk_in(clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in), .sda_in(sda_in),
    .scl_in(scl_in), .global_irq_en_in(global_irq_en_in), .vector_ack_in(vector_ack_in),
    .bus_change_irq_out(bus_change_irq_out), .event_irq_out(event_irq_out),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out));
`default_nettype wire

// [verification/tbcd_bus_host.sv]
// Model of the external two-wire host that attaches to and detaches from the bus.
`timescale 1ns/1ns
`default_nettype none
module tbcd_bus_host (
    // Clock of the sampling side.
    input  wire logic clk_in,
    // Bus line levels; pull-ups make a free bus idle high.
    output var logic  sda_out,
    output var logic  scl_out
);
    initial begin
        sda_out = 1'b1;
        scl_out = 1'b1;
    end
    // Levels change just after an edge so the detector never samples a race.
    task automatic drive(input logic sda, input logic scl);
        @(posedge clk_in);
        sda_out <= sda;
        scl_out <= scl;
    endtask
endmodule
`default_nettype wire

// [verification/tbcd_detector_test.sv]
// Self-checking bench of the bus connect/disconnect detector.
`timescale 1ns/1ns
`default_nettype none
module tbcd_detector_test;
    localparam logic [27:0] T0 = 28'h14;
    localparam logic [27:0] T1 = 28'h28;
    localparam logic [27:0] T2 = 28'h50;
    localparam logic [27:0] T3 = 28'hA0;
    localparam logic [2:0]  CS = tbcd_pkg::CTRL_STATUS_OFS;
    typedef struct {logic [1:0] tsel; int lim;} tbcd_row_t;
    tbcd_row_t  rows [4] = '{'{2'h0, int'(T0)}, '{2'h1, int'(T1)},
                             '{2'h2, int'(T2)}, '{2'h3, int'(T3)}};
    logic       clk_in = 1'b0;
    logic       rstn_in = 1'b0;
    logic       glb = 1'b0;
    logic       vack = 1'b0;
    logic       wr_in = 1'b0;
    logic       rd_in = 1'b0;
    logic [2:0] addr_in = 3'h0;
    logic [7:0] wdata_in = 8'h00;
    logic [7:0] rdata_out;
    logic       clk_en = 1'b1;
    logic       sda;
    logic       scl;
    logic       irq;
    logic       eirq;
    int         failures = 0;
    int         compares = 0;
    always #4 clk_in = ~clk_in;
    tbcd_bus_host host (.clk_in(clk_in), .sda_out(sda), .scl_out(scl));
    tbcd_detector #(.TOUT0_CYCLES(T0), .TOUT1_CYCLES(T1), .TOUT2_CYCLES(T2),
        .TOUT3_CYCLES(T3)) uut (
        .clk_in(clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en), .sda_in(sda),
        .scl_in(scl), .global_irq_en_in(glb), .vector_ack_in(vack),
        .bus_change_irq_out(irq), .event_irq_out(eirq), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_in);
        wr_in <= 1'b1; addr_in <= a; wdata_in <= v;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
        @(posedge clk_in);
        rd_in <= 1'b1; addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(n, e, rdata_out);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Bounded wait for the interrupt; a hang ends the run with a mismatch.
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
        chk("irq_wait", 8'h01, {7'h00, irq});
        if (irq !== 1'b1) summarize();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        cyc(2);
        rd(CS, 8'h80, "ctrl_after_high_reset");
        rd(tbcd_pkg::EVT_STATUS_OFS, 8'h04, "evt_after_reset");
        host.drive(1'b0, 1'b0);
        repeat (3) @(posedge clk_in);
        rstn_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        cyc(2);
        rd(CS, 8'h00, "ctrl_after_low_reset");
        wr(CS, 8'hFF);
        rd(CS, 8'h47, "ctrl_reserved");
        wr(5, 8'hFF);
        rd(5, 8'h00, "unmapped");
        // Connect with polarity clear, enable and event mask set.
        wr(CS, 8'h40);
        wr(tbcd_pkg::EVT_MASK_OFS, 8'h01);
        glb <= 1'b1;
        host.drive(1'b1, 1'b1);
        cyc(2);
        chk("irq_early", 8'h00, {7'h00, irq});
        wait_irq(3);
        chk("event_irq", 8'h01, {7'h00, eirq});
        wr(tbcd_pkg::EVT_MASK_OFS, 8'h00);
        #1 chk("event_masked", 8'h00, {7'h00, eirq});
        wr(tbcd_pkg::EVT_STATUS_OFS, 8'h07);
        wr(tbcd_pkg::EVT_MASK_OFS, 8'h07);
        #1 chk("event_cleared", 8'h00, {7'h00, eirq});
        @(posedge clk_in);
        glb <= 1'b0;
        #1 chk("irq_global_off", 8'h00, {7'h00, irq});
        @(posedge clk_in);
        glb <= 1'b1;
        vack <= 1'b1;
        @(posedge clk_in);
        vack <= 1'b0;
        #1 chk("irq_vector", 8'h00, {7'h00, irq});
        rd(CS, 8'h40, "ctrl_vector");
        // Software arms disconnect detection while the bus idles high.
        wr(CS, 8'h41);
        cyc(5);
        chk("irq_idle_high", 8'h00, {7'h00, irq});
        rd(tbcd_pkg::LINE_STATE_OFS, 8'h03, "lines_idle_high");
        // One disconnect per time-out code, each just short of and past its limit.
        foreach (rows[i]) begin
            wr(CS, {2'b01, 3'b000, rows[i].tsel, 1'b1});
            host.drive(1'b0, 1'b0);
            cyc(rows[i].lim);
            chk("irq_before_timeout", 8'h00, {7'h00, irq});
            wait_irq(8);
            rd(CS, {2'b11, 3'b000, rows[i].tsel, 1'b1}, "ctrl_disconnect");
            wr(CS, {2'b11, 3'b000, rows[i].tsel, 1'b1});
            host.drive(1'b1, 1'b1);
            cyc(5);
            chk("irq_connect_pol1", 8'h00, {7'h00, irq});
        end
        // A short high pulse in mid-count must restart the time-out.
        wr(CS, 8'h41);
        host.drive(1'b0, 1'b0);
        cyc(15);
        host.drive(1'b1, 1'b0);
        host.drive(1'b0, 1'b0);
        cyc(12);
        chk("irq_after_glitch", 8'h00, {7'h00, irq});
        rd(tbcd_pkg::LINE_STATE_OFS, 8'h04, "lines_low_timing");
        wait_irq(20);
        wr(CS, 8'h41);
        rd(CS, 8'hC1, "ctrl_write_zero");
        wr(CS, 8'hC1);
        rd(CS, 8'h41, "ctrl_write_one");
        // A write while the clock enable is low must leave the register alone.
        @(posedge clk_in);
        clk_en <= 1'b0;
        wr(CS, 8'h47);
        clk_en <= 1'b1;
        rd(CS, 8'h41, "ctrl_frozen");
        summarize();
    end
endmodule
`default_nettype wire
